// file: logic/slp_latch.sv
// Purpose: One 24-bit destination latch
// Assumes: Load is a single-cycle pulse
// Notes: Holds value until its own load
`default_nettype none
module slp_latch #(
    parameter int W = slp_pkg::WORD_W
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic load,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] dout_r;
    assign dout = dout_r;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            dout_r <= W'(slp_pkg::LATCH_RST);
        end else if (clk_en && load) begin
            dout_r <= din;
        end
    end
endmodule : slp_latch
`default_nettype wire

// file: logic/slp_shift.sv
// Purpose: 24-bit serial input shift register
// Assumes: Serial clock and data sampled on sys_clk
// Notes: Shifts MSB first toward the top
`default_nettype none
module slp_shift #(
    parameter int W = slp_pkg::WORD_W
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic shift_pulse,
    input wire logic serial_in_line,
    output logic [W-1:0] word
);
    logic [W-1:0] word_r;
    assign word = word_r;
    // Shift new bit into the low end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            word_r <= '0;
        end else if (clk_en && shift_pulse) begin
            word_r <= {word_r[W-2:0], serial_in_line};
        end
    end
endmodule : slp_shift
`default_nettype wire

// file: logic/slp_top.sv
// Purpose: Serial latch programming and band select sequencing
// Assumes: Serial pins sampled synchronously; lock and detector tick from analog side
// Notes: Latch outputs are raw 24-bit words plus decoded fields
`default_nettype none
module slp_top (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic serial_clk,
    input wire logic serial_in_line,
    input wire logic latch_load_strobe,
    input wire logic ref_tick,
    input wire logic digital_lock,
    output logic [23:0] main_config_latch,
    output logic [23:0] tx_phase_refdiv_latch,
    output logic [23:0] rx_calibration_latch,
    output logic [23:0] lo_latch,
    output logic [23:0] rx_filter_latch,
    output var slp_pkg::slp_main_s main_fields,
    output logic [12:0] ref_divide,
    output logic [1:0] band_clk_div,
    output logic [3:0] band_clk_ratio,
    output logic band_clk,
    output logic tuning_on_reference,
    output logic [3:0] band_index,
    output logic band_busy,
    output logic rf_stage_on,
    output logic tx_stage_on,
    output logic [1:0] lo_tail_sel,
    output logic tx_tail_high,
    output logic counters_held,
    output logic filter_cal_start
);
    localparam int W = slp_pkg::WORD_W;

    logic sclk_d_r;
    logic le_d_r;
    logic shift_pulse;
    logic load_pulse;
    logic [W-1:0] shift_word;
    logic [1:0] sel;
    logic sel_hi;
    logic ld_main;
    logic ld_tx;
    logic ld_cal;
    logic ld_lo;
    logic ld_rxf;
    logic [W-1:0] main_w;
    logic [W-1:0] cal_w;
    logic [1:0] bsc_r;
    logic [1:0] bsc_nxt;
    logic [2:0] div_cnt_r;
    logic [2:0] div_mask;
    logic band_tick;
    slp_pkg::slp_band_e state_r;
    slp_pkg::slp_band_e state_nxt;
    logic [2:0] cyc_r;
    logic [3:0] band_r;
    logic start_band;
    logic pwrup_r;
    logic cal_r;

    // Edge detect on sampled serial clock and load strobe
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sclk_d_r <= 1'b0;
            le_d_r <= 1'b0;
        end else if (clk_en) begin
            sclk_d_r <= serial_clk;
            le_d_r <= latch_load_strobe;
        end
    end
    assign shift_pulse = serial_clk && !sclk_d_r;
    assign load_pulse = latch_load_strobe && !le_d_r;

    slp_shift #(.W(W)) u_shift (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .shift_pulse(shift_pulse),
        .serial_in_line(serial_in_line),
        .word(shift_word)
    );

    assign sel = shift_word[1:0];
    assign sel_hi = shift_word[slp_pkg::SEL_HI];
    assign ld_main = load_pulse && (sel == slp_pkg::SEL_MAIN);
    assign ld_tx = load_pulse && (sel == slp_pkg::SEL_TXCAL) && !sel_hi;
    assign ld_cal = load_pulse && (sel == slp_pkg::SEL_TXCAL) && sel_hi;
    assign ld_lo = load_pulse && (sel == slp_pkg::SEL_LO);
    assign ld_rxf = load_pulse && (sel == slp_pkg::SEL_RXF);

    slp_latch #(.W(W)) u_main (
        .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
        .load(ld_main), .din(shift_word), .dout(main_w)
    );
    slp_latch #(.W(W)) u_tx (
        .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
        .load(ld_tx), .din(shift_word), .dout(tx_phase_refdiv_latch)
    );
    slp_latch #(.W(W)) u_cal (
        .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
        .load(ld_cal), .din(shift_word), .dout(cal_w)
    );
    slp_latch #(.W(W)) u_lo (
        .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
        .load(ld_lo), .din(shift_word), .dout(lo_latch)
    );
    slp_latch #(.W(W)) u_rxf (
        .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
        .load(ld_rxf), .din(shift_word), .dout(rx_filter_latch)
    );
    assign main_config_latch = main_w;
    assign rx_calibration_latch = cal_w;

    assign main_fields.powerdown = main_w[slp_pkg::PD_LSB +: 4];
    assign main_fields.out_power = main_w[slp_pkg::OUTP_LSB +: 2];
    assign main_fields.pump_current = main_w[slp_pkg::PUMP_LSB +: 3];
    assign main_fields.lo_power = main_w[slp_pkg::LOP_LSB +: 2];
    assign main_fields.mute_rf_until_lock = main_w[slp_pkg::MUTE_RF_BIT];
    assign main_fields.mute_tx_until_lock = main_w[slp_pkg::MUTE_TX_BIT];
    assign main_fields.pump_tristate = main_w[slp_pkg::TRI_BIT];
    assign main_fields.detector_polarity = main_w[slp_pkg::POL_BIT];
    assign main_fields.monitor_select = main_w[slp_pkg::MON_LSB +: 3];
    assign main_fields.counter_hold = main_w[slp_pkg::HOLD_BIT];

    assign ref_divide = tx_phase_refdiv_latch[slp_pkg::REF_LSB +: 13];
    // Counters held while hold bit set
    assign counters_held = main_fields.counter_hold;
    assign lo_tail_sel = main_fields.out_power;
    assign tx_tail_high = main_fields.out_power[1];

    // Band clock divider from either latch
    always_comb begin
        bsc_nxt = bsc_r;
        if (ld_tx || ld_cal) begin
            bsc_nxt = shift_word[slp_pkg::BSC_LSB +: 2];
        end
    end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bsc_r <= 2'h0;
        end else if (clk_en) begin
            bsc_r <= bsc_nxt;
        end
    end
    assign band_clk_div = bsc_r;

    // Divide reference ticks by 1, 2, 4 or 8
    assign div_mask = 3'((4'h1 << bsc_r) - 4'h1);
    assign band_clk_ratio = 4'h1 << bsc_r;
    assign band_tick = ref_tick && ((div_cnt_r & div_mask) == div_mask);
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            div_cnt_r <= 3'h0;
        end else if (clk_en && ref_tick) begin
            div_cnt_r <= div_cnt_r + 3'h1;
        end
    end
    assign band_clk = band_tick;

    // Start at power-up and on each LO write
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pwrup_r <= 1'b1;
        end else if (clk_en && state_r == slp_pkg::SLP_BAND) begin
            pwrup_r <= 1'b0;
        end
    end
    assign start_band = ld_lo || pwrup_r;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            slp_pkg::SLP_IDLE, slp_pkg::SLP_LOCKED: begin
                if (start_band) begin
                    state_nxt = slp_pkg::SLP_BAND;
                end
            end
            slp_pkg::SLP_BAND: begin
                if (ld_lo) begin
                    state_nxt = slp_pkg::SLP_BAND;
                end else if (band_tick && cyc_r == slp_pkg::BAND_CYCLES - 3'h1) begin
                    state_nxt = slp_pkg::SLP_LOCKED;
                end
            end
            default: begin
                state_nxt = slp_pkg::SLP_IDLE;
            end
        endcase
    end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_r <= slp_pkg::SLP_IDLE;
            cyc_r <= 3'h0;
            band_r <= 4'h0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            if (state_r != slp_pkg::SLP_BAND || ld_lo) begin
                cyc_r <= 3'h0;
            end else if (band_tick) begin
                cyc_r <= cyc_r + 3'h1;
                // Step one band per band tick, holding at band 15, while the node sits on the reference
                if (band_r != slp_pkg::BAND_COUNT_MAX) begin
                    band_r <= band_r + 4'h1;
                end
            end
            if (start_band && state_r != slp_pkg::SLP_BAND) begin
                band_r <= 4'h0;
            end
        end
    end
    assign band_busy = (state_r == slp_pkg::SLP_BAND);
    assign tuning_on_reference = band_busy;
    assign band_index = band_r;

    assign rf_stage_on = !main_fields.powerdown[1]
        && (!main_fields.mute_rf_until_lock || digital_lock);
    assign tx_stage_on = !main_fields.powerdown[0]
        && (!main_fields.mute_tx_until_lock || digital_lock);

    // Calibration start pulse on triggered write
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cal_r <= 1'b0;
        end else if (clk_en) begin
            cal_r <= ld_cal && shift_word[slp_pkg::TRIG_BIT];
        end
    end
    assign filter_cal_start = cal_r;

    // A load edge picks exactly one latch
    chk_one_latch: assert property (@(posedge sys_clk) disable iff (reset)
        $onehot0({ld_main, ld_tx, ld_cal, ld_lo, ld_rxf})
        && ((ld_main || ld_tx || ld_cal || ld_lo || ld_rxf) == load_pulse))
        else $error("latch load count wrong");
    // Rising serial clock shifts toward the top
    chk_shift_in: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && shift_pulse
        |=> shift_word == {$past(shift_word[W-2:0]), $past(serial_in_line)})
        else $error("serial bit not shifted in");
    // No shift without a serial clock edge
    chk_shift_holds: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && !shift_pulse |=> $stable(shift_word))
        else $error("shift without clock edge");
    chk_powerup_band: assert property (@(posedge sys_clk) disable iff (reset)
        $fell(reset) && clk_en |=> band_busy)
        else $error("no band select after power-up");
    chk_lo_starts_band: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && ld_lo |=> band_busy)
        else $error("LO write did not start band select");
    // LO write during selection restarts the count
    chk_band_restart: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && band_busy && ld_lo |=> band_busy && cyc_r == 3'h0)
        else $error("band select not restarted");
    // Each band tick advances the count
    chk_band_tick_count: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && band_busy && band_tick && !ld_lo && cyc_r < slp_pkg::BAND_CYCLES - 3'h1
        |=> band_busy && cyc_r == $past(cyc_r) + 3'h1)
        else $error("band cycle not counted");
    // Node leaves the reference only after the last tick
    chk_tune_follows_band: assert property (@(posedge sys_clk) disable iff (reset)
        $fell(tuning_on_reference)
        |-> $past(band_tick) && $past(cyc_r) == slp_pkg::BAND_CYCLES - 3'h1)
        else $error("tuning node left reference early");
    // Latches keep their words without a load edge
    chk_latches_hold: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && !load_pulse |=> $stable(main_config_latch) && $stable(lo_latch)
        && $stable(tx_phase_refdiv_latch) && $stable(rx_calibration_latch)
        && $stable(rx_filter_latch))
        else $error("latch changed without load");
    // Main latch takes the shifted word
    chk_main_loads: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && ld_main |=> main_config_latch == $past(shift_word))
        else $error("main latch did not take word");
    // Transmit latch takes the shifted word
    chk_tx_loads: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && ld_tx |=> tx_phase_refdiv_latch == $past(shift_word))
        else $error("tx latch did not take word");
    // Calibration latch takes the shifted word
    chk_cal_loads: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && ld_cal |=> rx_calibration_latch == $past(shift_word))
        else $error("cal latch did not take word");
    chk_lo_loads: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && ld_lo |=> lo_latch == $past(shift_word))
        else $error("lo latch did not take word");
    // Receive filter latch takes its word
    chk_rxf_loads: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && ld_rxf |=> rx_filter_latch == $past(shift_word))
        else $error("rxf latch did not take word");
    chk_tx_mute: assert property (@(posedge sys_clk) disable iff (reset)
        main_fields.mute_tx_until_lock && !digital_lock |-> !tx_stage_on)
        else $error("transmit stage on before lock");
    chk_rf_mute: assert property (@(posedge sys_clk) disable iff (reset)
        main_fields.mute_rf_until_lock && !digital_lock |-> !rf_stage_on)
        else $error("rf stage on before lock");
    // Power-down bits switch the stages off
    chk_tx_powerdown: assert property (@(posedge sys_clk) disable iff (reset)
        main_fields.powerdown[0] |-> !tx_stage_on)
        else $error("tx stage on while powered down");
    // Oscillator power-down stops the RF stage
    chk_rf_powerdown: assert property (@(posedge sys_clk) disable iff (reset)
        main_fields.powerdown[1] |-> !rf_stage_on)
        else $error("rf stage on while powered down");
    chk_counter_hold: assert property (@(posedge sys_clk) disable iff (reset)
        counters_held == main_config_latch[slp_pkg::HOLD_BIT])
        else $error("counter hold wrong");
    // Pulse only after a calibration write
    chk_cal_pulse: assert property (@(posedge sys_clk) disable iff (reset)
        filter_cal_start |-> $past(ld_cal))
        else $error("calibration start without calibration write");
    chk_cal_trigger: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && ld_cal |=> filter_cal_start == $past(shift_word[slp_pkg::TRIG_BIT]))
        else $error("calibration start wrong");
    // Transmit write sets the band clock divider
    chk_div_update: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && ld_tx |=> band_clk_div == $past(shift_word[17:16]))
        else $error("band clock divider not updated");
    // Calibration write sets the divider too
    chk_div_cal_update: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && ld_cal |=> band_clk_div == $past(shift_word[17:16]))
        else $error("divider not set by cal write");
    chk_div_holds: assert property (@(posedge sys_clk) disable iff (reset)
        clk_en && !ld_tx && !ld_cal |=> $stable(band_clk_div))
        else $error("divider changed without write");
    // Divide by one passes every reference tick
    chk_div_by_one: assert property (@(posedge sys_clk) disable iff (reset)
        band_clk_div == 2'h0 |-> band_clk == ref_tick)
        else $error("band clock not reference tick");
endmodule : slp_top
`default_nettype wire

// file: shared/slp_pkg.sv
// What this block does
// - Each rising serial clock edge shifts one data bit into the 24-bit register.
// - Words arrive most significant bit first; first bit ends at the top.
// - Load strobe rising edge copies the shift register into exactly one latch.
// - Destination chosen from the two lowest bits of the shifted word; bit 2 also splits code 01.
// - 00 main, 10 LO, 001 transmit, 101 calibration, 11 receive filter.
// - Band selection runs at power-up and on every LO latch write; 16 bands.
// - Band selection lasts five band clock cycles with tuning node on reference.
// - Band clock divider divides by 1, 2, 4 or 8 from two field bits.
// - After band selection the tuning node returns to the loop filter.
// - Two output-power bits select one of four LO tail currents.
// - RF mute bit keeps RF output stage off until digital lock.
// - Transmit mute bit keeps transmit output stage off until digital lock.
// - Transmit stage has two tail-current levels from the output-power bits.
// - Main latch field layout from power-down bits down to counter hold.
// - Transmit latch: phases, band clock divider, 13-bit reference ratio, select bit zero.
// - Calibration latch: phases, divider, trigger, cal divider, boost timeout, bit one.
// - A one in each power-down bit disables its section; the code acts only on bit 0 (transmit) and bit 1 (RF).
// - Counter hold bit high keeps reference and feedback counters in reset.
// - Writing calibration latch with trigger high starts a filter calibration.
//
// Purpose: Shared constants and types of the serial latch programming block
// Assumes: Serial pins already synchronous to sys_clk
// Notes: Field positions are bit indices within the 24-bit word
`default_nettype none
package slp_pkg;
    localparam int WORD_W = 24;
    localparam int SEL_HI = 2;
    // Select codes on the two low bits
    localparam logic [1:0] SEL_MAIN = 2'h0;
    localparam logic [1:0] SEL_TXCAL = 2'h1;
    localparam logic [1:0] SEL_LO = 2'h2;
    localparam logic [1:0] SEL_RXF = 2'h3;
    // Main latch fields
    localparam int PD_LSB = 19;
    localparam int OUTP_LSB = 17;
    localparam int PUMP_LSB = 14;
    localparam int LOP_LSB = 12;
    localparam int MUTE_TX_BIT = 11;
    localparam int MUTE_RF_BIT = 10;
    localparam int TRI_BIT = 9;
    localparam int POL_BIT = 8;
    localparam int MON_LSB = 5;
    localparam int HOLD_BIT = 4;
    // Transmit and calibration fields
    localparam int RXPH_LSB = 21;
    localparam int MODPH_LSB = 18;
    localparam int BSC_LSB = 16;
    localparam int REF_LSB = 3;
    localparam int TRIG_BIT = 15;
    localparam int CALDIV_LSB = 9;
    localparam int BOOST_LSB = 3;
    // Band selection length in band clock cycles
    localparam logic [2:0] BAND_CYCLES = 3'h5;
    localparam logic [3:0] BAND_COUNT_MAX = 4'hf;
    localparam logic [WORD_W-1:0] LATCH_RST = 24'h00_0000;

    typedef enum logic [1:0] {
        SLP_IDLE,
        SLP_BAND,
        SLP_LOCKED
    } slp_band_e;

    typedef struct packed {
        logic [3:0] powerdown;
        logic [1:0] out_power;
        logic [2:0] pump_current;
        logic [1:0] lo_power;
        logic mute_tx_until_lock;
        logic mute_rf_until_lock;
        logic pump_tristate;
        logic detector_polarity;
        logic [2:0] monitor_select;
        logic counter_hold;
    } slp_main_s;
endpackage : slp_pkg
`default_nettype wire

// file: testbench/slp_host_model.sv
// Purpose: Host side of the three-wire programming path
// Assumes: Bench calls send from its main sequence
// Notes: Serial clock rests low between words
`default_nettype none
module slp_host_model (
    input wire logic sys_clk,
    output logic serial_clk,
    output logic serial_in_line,
    output logic latch_load_strobe
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle pins at time zero
    initial begin
        serial_clk = 1'b0;
        serial_in_line = 1'b0;
        latch_load_strobe = 1'b0;
    end

    task automatic send(input logic [23:0] w, input logic load);
        for (int i = 23; i >= 0; i--) begin
            @(posedge sys_clk);
            serial_clk <= 1'b0;
            serial_in_line <= w[i];
            @(posedge sys_clk);
            serial_clk <= 1'b1;
        end
        @(posedge sys_clk);
        serial_clk <= 1'b0;
        serial_in_line <= ~w[0]; // Released line no longer shows the last bit
        if (load) begin
            @(posedge sys_clk);
            latch_load_strobe <= 1'b1;
            @(posedge sys_clk);
            latch_load_strobe <= 1'b0;
        end
        repeat (3) @(posedge sys_clk);
    endtask : send
endmodule : slp_host_model
`default_nettype wire

// file: testbench/tb_serial_latch_programming.sv
// Purpose: Self-checking bench for the serial latch programming block
// Assumes: Reference tick every 12 cycles keeps the band clock under 1 MHz
// Notes: Shadow latches predict every destination
`default_nettype none
module tb_serial_latch_programming;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, reset, clk_en, ref_tick, digital_lock;
    logic serial_clk, serial_in_line, latch_load_strobe;
    logic [23:0] main_config_latch, tx_phase_refdiv_latch, rx_calibration_latch;
    logic [23:0] lo_latch, rx_filter_latch;
    slp_pkg::slp_main_s main_fields;
    logic [12:0] ref_divide;
    logic [1:0] band_clk_div, lo_tail_sel;
    logic [3:0] band_clk_ratio, band_index;
    logic band_clk, tuning_on_reference, band_busy, rf_stage_on, tx_stage_on;
    logic tx_tail_high, counters_held, filter_cal_start;
    int miscompares, samples_checked, seed, cal_pulses, band_pulses, tick_cnt;
    logic [23:0] exp_l [5];

    slp_top u_slp_top (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
        .serial_clk(serial_clk), .serial_in_line(serial_in_line),
        .latch_load_strobe(latch_load_strobe), .ref_tick(ref_tick),
        .digital_lock(digital_lock), .main_config_latch(main_config_latch),
        .tx_phase_refdiv_latch(tx_phase_refdiv_latch),
        .rx_calibration_latch(rx_calibration_latch), .lo_latch(lo_latch),
        .rx_filter_latch(rx_filter_latch), .main_fields(main_fields),
        .ref_divide(ref_divide), .band_clk_div(band_clk_div),
        .band_clk_ratio(band_clk_ratio), .band_clk(band_clk),
        .tuning_on_reference(tuning_on_reference), .band_index(band_index),
        .band_busy(band_busy), .rf_stage_on(rf_stage_on), .tx_stage_on(tx_stage_on),
        .lo_tail_sel(lo_tail_sel), .tx_tail_high(tx_tail_high),
        .counters_held(counters_held), .filter_cal_start(filter_cal_start));
    slp_host_model u_slp_host_model (.sys_clk(sys_clk), .serial_clk(serial_clk),
        .serial_in_line(serial_in_line), .latch_load_strobe(latch_load_strobe));

    // Clock of 100 ns period
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Slow reference tick and pulse counters
    initial tick_cnt = 0;
    always @(posedge sys_clk) begin
        tick_cnt <= (tick_cnt == 11) ? 0 : tick_cnt + 1;
        ref_tick <= (tick_cnt == 11);
        if (filter_cal_start === 1'b1) cal_pulses <= cal_pulses + 1;
        if (band_busy === 1'b1 && band_clk === 1'b1) band_pulses <= band_pulses + 1;
    end

    task automatic chk_word(input string what, input logic [23:0] e, input logic [23:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask : chk_word

    task automatic chk_bit(input string what, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %b seen %b", what, e, g);
        end
    endtask : chk_bit

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_of_test

    // Host shapes words: test bits zero, spare bits 0 and 1
    function automatic logic [23:0] make_word(input int sel, input logic [23:0] r);
        case (sel)
            0: return {1'b0, r[22:4], 4'h4};
            1: return {r[23:3], 3'h1};
            2: return {r[23:3], 3'h5};
            3: return {r[23:2], 2'h2};
            default: return {16'h0000, r[7:2], 2'h3};
        endcase
    endfunction : make_word

    task automatic put(input int sel, input logic [23:0] w, input logic load);
        u_slp_host_model.send(w, load);
        if (load) exp_l[sel] = w;
        #1;
        chk_word("main latch", exp_l[0], main_config_latch);
        chk_word("tx latch", exp_l[1], tx_phase_refdiv_latch);
        chk_word("cal latch", exp_l[2], rx_calibration_latch);
        chk_word("lo latch", exp_l[3], lo_latch);
        chk_word("rxf latch", exp_l[4], rx_filter_latch);
    endtask : put

    task automatic wait_idle;
        for (int k = 0; k < 2000 && band_busy !== 1'b0; k++) @(posedge sys_clk);
        #1;
        chk_bit("idle", 1'b0, band_busy);
    endtask : wait_idle

    // Watchdog far beyond the expected run
    initial begin
        #5ms;
        miscompares++;
        end_of_test();
    end

    // Main sequence
    initial begin
        logic [23:0] w;
        int sel, c0, b0;
        seed = 61;
        reset = 1'b1;
        clk_en = 1'b1;
        digital_lock = 1'b0;
        cal_pulses = 0;
        band_pulses = 0;
        for (int i = 0; i < 5; i++) exp_l[i] = slp_pkg::LATCH_RST;
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        chk_bit("powerup busy", 1'b1, band_busy);
        put(0, 24'h00_0000, 1'b0);
        $display("test reset done");
        for (int n = 0; n < 15; n++) begin
            put(n % 5, make_word(n % 5, 24'($random(seed))), 1'b1);
            put(0, 24'($random(seed)), 1'b0);
        end
        $display("test routing done");
        for (int i = 0; i < 8; i++) begin
            w = make_word(0, 24'($random(seed)));
            w[11:10] = 2'(i);
            if (i < 4) w[20:19] = 2'h0;
            put(0, w, 1'b1);
            for (int lk = 0; lk < 2; lk++) begin
                @(posedge sys_clk);
                digital_lock <= 1'(lk);
                @(posedge sys_clk);
                #1;
                chk_word("fields", 24'(w[22:4]), 24'(main_fields));
                chk_word("lo tail", 24'(w[18:17]), 24'(lo_tail_sel));
                chk_bit("tx tail", w[18], tx_tail_high);
                chk_bit("hold", w[4], counters_held);
                chk_bit("rf on", !w[20] && (!w[10] || lk == 1), rf_stage_on);
                chk_bit("tx on", !w[19] && (!w[11] || lk == 1), tx_stage_on);
            end
        end
        $display("test fields done");
        for (int d = 0; d < 4; d++) begin
            wait_idle();
            sel = (d % 2 == 1) ? 2 : 1;
            w = make_word(sel, 24'($random(seed)));
            w[17:16] = 2'(d);
            w[15] = (d > 1);
            c0 = cal_pulses;
            put(sel, w, 1'b1);
            repeat (2) @(posedge sys_clk);
            #1;
            if (sel == 1) chk_word("ref div", 24'(w[15:3]), 24'(ref_divide));
            chk_word("bsc div", 24'(d), 24'(band_clk_div));
            chk_word("bsc ratio", 24'(4'h1 << d), 24'(band_clk_ratio));
            chk_word("cal count", 24'(sel == 2 && d > 1), 24'(cal_pulses - c0));
            b0 = band_pulses;
            put(3, make_word(3, 24'($random(seed))), 1'b1);
            chk_bit("lo busy", 1'b1, band_busy);
            chk_bit("on ref", 1'b1, tuning_on_reference);
            wait_idle();
            chk_word("band pulses", 24'h00_0005, 24'(band_pulses - b0));
            chk_bit("back on loop", 1'b0, tuning_on_reference);
            chk_word("band index", 24'(slp_pkg::BAND_CYCLES), 24'(band_index));
        end
        $display("test band select done");
        end_of_test();
    end
endmodule : tb_serial_latch_programming
`default_nettype wire
